// >>> link_pkt_pkg.sv
// Package for the serial bus link packet handling block.
// Assumes a 100 MHz system clock and a classic Wishbone register port.
package link_pkt_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_ASYINT   = 8'h08;
   localparam logic [7:0] OFS_TX_REQ   = 8'h0C;
   localparam logic [7:0] OFS_TX_RSP   = 8'h10;
   localparam logic [7:0] OFS_RX_REQ   = 8'h14;
   localparam logic [7:0] OFS_RX_RSP   = 8'h18;
   localparam logic [7:0] OFS_ISO_INT  = 8'h4C;

   // Control bits
   localparam int CTRL_ACCEPT_ALL   = 0;
   localparam int CTRL_ISO_RX_EN    = 1;
   localparam int CTRL_CYCLE_MASTER = 11;

   // Status bits
   localparam int ST_TX_REQ_IDLE  = 0;
   localparam int ST_TX_RSP_IDLE  = 1;
   localparam int ST_TX_REQ_FULL  = 3;
   localparam int ST_TX_RSP_FULL  = 7;
   localparam int ST_RX_REQ_EMPTY = 8;
   localparam int ST_RX_RSP_EMPTY = 9;

   // Sticky event bits, write one to clear
   localparam int EV_RX_REQ_QAV   = 0;
   localparam int EV_SELFID       = 1;
   localparam int EV_CYCLE_TMOUT  = 2;
   localparam int EV_RX_REQ_FULL  = 3;
   localparam int EV_RX_RSP_FULL  = 4;

   // Iso receive event bits
   localparam int ISO_TAG_FAULT   = 0;
   localparam int ISO_BAD_PACKET  = 1;

   // Quadlet constants
   localparam logic [31:0] SELFID_HEADER = 32'h0000_00E0;
   localparam logic [31:0] SELFID_TAIL   = 32'h0000_0001;
   localparam logic [31:0] PHY_HEADER    = 32'h0000_00E0;
   localparam logic [31:0] CONFIRM_HDR   = 32'h0000_00C0;
   localparam logic [9:0]  LOCAL_BUS     = 10'h3FF;
   localparam logic [3:0]  ACK_COMPLETE  = 4'h1;
   localparam logic [3:0]  ACK_MISSING   = 4'h0;

   // Queue sizes
   localparam int QUAD_W       = 32;
   localparam int TX_DEPTH     = 64;
   localparam int TX_AW        = 6;
   localparam int RX_DEPTH     = 64;
   localparam int RX_AW        = 6;

   // Cycle timeout
   localparam int CLK_MHZ        = 100;
   localparam int CYCLE_TMOUT_US = 125;
   localparam int CYCLE_TMOUT_CYC = CYCLE_TMOUT_US * CLK_MHZ;

   // Receive sequencer states
   typedef enum logic [2:0] {
      RX_IDLE    = 3'b000,
      RX_SID_HDR = 3'b001,
      RX_SID_BODY= 3'b010,
      RX_SID_END = 3'b011,
      RX_PHY_HDR = 3'b100,
      RX_PHY_BODY= 3'b101,
      RX_CONFIRM = 3'b110,
      RX_PASS    = 3'b111
   } rx_state_t;

endpackage

// >>> quad_fifo.sv
// Synchronous quadlet FIFO with flush.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
module quad_fifo #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        flush_i,
   input  wire logic        wr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   output logic             empty_o,
   output logic             full_o
);

   logic [31:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic        do_wr;
   logic        do_rd;

   assign do_wr   = wr_i && !full_o;
   assign do_rd   = rd_i && !empty_o;
   assign empty_o = (wp_r == rp_r);
   assign full_o  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign rdata_o = mem[rp_r[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (do_wr)
      begin
         mem[wp_r[AW-1:0]] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || flush_i)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wp_r <= wp_r + 1'b1;
         end
         if (do_rd)
         begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end

endmodule

// >>> link_pkt.sv
// Packet handling of a serial bus link: transmit transfer registers and queues,
// receive filtering, synthesized confirmation, self-ID and PHY packet delivery.
// Assumes a decoded receive quadlet stream and PHY side event strobes.
//
// Functional notes
// - Accept-all stores every response; otherwise only solicited responses are stored.
// - Request with no acknowledge yields a synthesized confirmation in request queue.
// - A queued confirmation also raises the request quadlet-available flag.
// - Receipt of a self-ID packet sets the self-ID quadlet flag.
// - Bus reset flushes queues, then self-ID packet goes to request queue.
// - Self-ID layout: header E0, inverse pairs, final quadlet 1.
// - PHY packet delivered as header E0 plus first non-inverted quadlet.
// - Broadcast to a remote bus (not 3FF) confirms with ack_complete.
// - Lock responses, including zero length errors, reach receive FIFO when accept-all is set or they are solicited.
// - Transmit path holds packets of up to 65 quadlets.
// - Host write to a transfer register clears its idle flag.
// - Idle flag sets again once the quadlet moved into its FIFO.
// - Cycle timeout flagged when 125 us pass from cycle start to gap.
// - Iso tag fault and bad packet bits stay clear while receiver disabled.
`timescale 1ns/1ps
module link_pkt (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Transmit queue drain toward the PHY
   input  wire logic        tx_req_pop_i,
   input  wire logic        tx_rsp_pop_i,
   output logic [31:0]      tx_req_data_o,
   output logic [31:0]      tx_rsp_data_o,
   output logic             tx_req_avail_o,
   output logic             tx_rsp_avail_o,
   // Received quadlet stream
   input  wire logic        rx_valid_i,
   input  wire logic [31:0] rx_data_i,
   input  wire logic        rx_first_i,
   input  wire logic        rx_last_i,
   input  wire logic        rx_is_response_i,
   input  wire logic        rx_solicited_i,
   input  wire logic        rx_is_selfid_i,
   input  wire logic        rx_is_phy_i,
   // Transmit outcome events
   input  wire logic        tx_done_i,
   input  wire logic        tx_ack_seen_i,
   input  wire logic [3:0]  tx_ack_code_i,
   input  wire logic        tx_broadcast_i,
   input  wire logic [9:0]  tx_bus_id_i,
   // Bus events
   input  wire logic        bus_reset_i,
   input  wire logic        cycle_start_i,
   input  wire logic        subaction_gap_i,
   input  wire logic        iso_tag_fault_i,
   input  wire logic        iso_bad_packet_i,
   output logic             cycle_master_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] ctrl_r;
   logic [4:0]  ev_r;
   logic [1:0]  iso_r;
   logic [31:0] tx_req_hold_r;
   logic [31:0] tx_rsp_hold_r;
   logic        tx_req_idle_r;
   logic        tx_rsp_idle_r;
   logic [13:0] tmo_cnt_r;
   logic        tmo_run_r;
   link_pkt_pkg::rx_state_t rx_state_r;
   logic [31:0] rx_hold_r;
   logic [31:0] rx_req_wdata;
   logic        rx_req_wr;
   logic [31:0] rx_rsp_wdata;
   logic        rx_rsp_wr;
   logic        flush;

   logic        bus_wr;
   logic        bus_rd;
   logic        tx_req_full;
   logic        tx_rsp_full;
   logic        tx_req_empty;
   logic        tx_rsp_empty;
   logic        rx_req_full;
   logic        rx_rsp_full;
   logic        rx_req_empty;
   logic        rx_rsp_empty;
   logic [31:0] rx_req_rdata;
   logic [31:0] rx_rsp_rdata;
   logic        rx_req_pop;
   logic        rx_rsp_pop;
   logic [4:0]  ev_set;
   logic [1:0]  iso_set;

   assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign bus_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign flush  = bus_reset_i;
   assign rx_req_pop = bus_rd && (wb_adr_i == link_pkt_pkg::OFS_RX_REQ);
   assign rx_rsp_pop = bus_rd && (wb_adr_i == link_pkt_pkg::OFS_RX_RSP);

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Transmit queues
   quad_fifo #(.DEPTH(link_pkt_pkg::TX_DEPTH), .AW(link_pkt_pkg::TX_AW)) u_tx_req (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .flush_i (flush),
      .wr_i    (!tx_req_idle_r),
      .wdata_i (tx_req_hold_r),
      .rd_i    (tx_req_pop_i),
      .rdata_o (tx_req_data_o),
      .empty_o (tx_req_empty),
      .full_o  (tx_req_full)
   );

   quad_fifo #(.DEPTH(link_pkt_pkg::TX_DEPTH), .AW(link_pkt_pkg::TX_AW)) u_tx_rsp (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .flush_i (flush),
      .wr_i    (!tx_rsp_idle_r),
      .wdata_i (tx_rsp_hold_r),
      .rd_i    (tx_rsp_pop_i),
      .rdata_o (tx_rsp_data_o),
      .empty_o (tx_rsp_empty),
      .full_o  (tx_rsp_full)
   );

   assign tx_req_avail_o = !tx_req_empty;
   assign tx_rsp_avail_o = !tx_rsp_empty;

   // Transfer registers and idle flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_req_idle_r <= 1'b1;
         tx_rsp_idle_r <= 1'b1;
         tx_req_hold_r <= '0;
         tx_rsp_hold_r <= '0;
      end
      else
      begin
         if (bus_wr && wb_adr_i == link_pkt_pkg::OFS_TX_REQ)
         begin
            tx_req_hold_r <= merge(tx_req_hold_r, wb_dat_i, wb_sel_i);
            tx_req_idle_r <= 1'b0;
         end
         else if (!tx_req_idle_r && (!tx_req_full || flush))
         begin
            tx_req_idle_r <= 1'b1;
         end
         if (bus_wr && wb_adr_i == link_pkt_pkg::OFS_TX_RSP)
         begin
            tx_rsp_hold_r <= merge(tx_rsp_hold_r, wb_dat_i, wb_sel_i);
            tx_rsp_idle_r <= 1'b0;
         end
         else if (!tx_rsp_idle_r && (!tx_rsp_full || flush))
         begin
            tx_rsp_idle_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive queues
   quad_fifo #(.DEPTH(link_pkt_pkg::RX_DEPTH), .AW(link_pkt_pkg::RX_AW)) u_rx_req (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .flush_i (flush),
      .wr_i    (rx_req_wr),
      .wdata_i (rx_req_wdata),
      .rd_i    (rx_req_pop),
      .rdata_o (rx_req_rdata),
      .empty_o (rx_req_empty),
      .full_o  (rx_req_full)
   );

   quad_fifo #(.DEPTH(link_pkt_pkg::RX_DEPTH), .AW(link_pkt_pkg::RX_AW)) u_rx_rsp (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .flush_i (flush),
      .wr_i    (rx_rsp_wr),
      .wdata_i (rx_rsp_wdata),
      .rd_i    (rx_rsp_pop),
      .rdata_o (rx_rsp_rdata),
      .empty_o (rx_rsp_empty),
      .full_o  (rx_rsp_full)
   );

   // Receive sequencer: self-ID framing, PHY packets, confirmations
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_state_r <= link_pkt_pkg::RX_IDLE;
         rx_hold_r  <= '0;
      end
      else if (bus_reset_i)
      begin
         rx_state_r <= link_pkt_pkg::RX_SID_HDR;
      end
      else
      begin
         unique case (rx_state_r)
            link_pkt_pkg::RX_IDLE:
            begin
               if (tx_done_i && !tx_ack_seen_i)
               begin
                  rx_hold_r  <= {link_pkt_pkg::CONFIRM_HDR[31:4],
                     (tx_broadcast_i && tx_bus_id_i != link_pkt_pkg::LOCAL_BUS) ?
                     link_pkt_pkg::ACK_COMPLETE : link_pkt_pkg::ACK_MISSING};
                  rx_state_r <= link_pkt_pkg::RX_CONFIRM;
               end
               else if (rx_valid_i && rx_is_phy_i && rx_first_i)
               begin
                  rx_hold_r  <= rx_data_i;
                  rx_state_r <= link_pkt_pkg::RX_PHY_BODY;
               end
            end
            link_pkt_pkg::RX_SID_HDR:
            begin
               rx_state_r <= link_pkt_pkg::RX_SID_BODY;
            end
            link_pkt_pkg::RX_SID_BODY:
            begin
               if (rx_valid_i && rx_is_selfid_i && rx_last_i)
               begin
                  rx_state_r <= link_pkt_pkg::RX_SID_END;
               end
               else if (rx_valid_i && !rx_is_selfid_i)
               begin
                  rx_state_r <= link_pkt_pkg::RX_SID_END;
               end
            end
            default:
            begin
               rx_state_r <= link_pkt_pkg::RX_IDLE;
            end
         endcase
      end
   end

   // Queue write steering
   always_comb
   begin
      rx_req_wr    = 1'b0;
      rx_req_wdata = rx_data_i;
      rx_rsp_wr    = 1'b0;
      rx_rsp_wdata = rx_data_i;
      unique case (rx_state_r)
         link_pkt_pkg::RX_SID_HDR:
         begin
            rx_req_wr    = 1'b1;
            rx_req_wdata = link_pkt_pkg::SELFID_HEADER;
         end
         link_pkt_pkg::RX_SID_BODY:
         begin
            rx_req_wr = rx_valid_i && rx_is_selfid_i;
         end
         link_pkt_pkg::RX_SID_END:
         begin
            rx_req_wr    = 1'b1;
            rx_req_wdata = link_pkt_pkg::SELFID_TAIL;
         end
         link_pkt_pkg::RX_PHY_BODY:
         begin
            rx_req_wr    = 1'b1;
            rx_req_wdata = rx_hold_r;
         end
         link_pkt_pkg::RX_CONFIRM:
         begin
            rx_req_wr    = 1'b1;
            rx_req_wdata = rx_hold_r;
         end
         link_pkt_pkg::RX_IDLE:
         begin
            if (rx_valid_i && rx_is_phy_i && rx_first_i)
            begin
               rx_req_wr    = 1'b1;
               rx_req_wdata = link_pkt_pkg::PHY_HEADER;
            end
            else if (rx_valid_i && rx_is_response_i)
            begin
               // Lock responses of any length and rcode pass through
               rx_rsp_wr = ctrl_r[link_pkt_pkg::CTRL_ACCEPT_ALL] || rx_solicited_i;
            end
            else if (rx_valid_i && !rx_is_phy_i && !rx_is_selfid_i)
            begin
               rx_req_wr = 1'b1;
            end
         end
         default:
         begin
            rx_req_wr = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle timeout counter
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tmo_run_r <= 1'b0;
         tmo_cnt_r <= '0;
      end
      else if (cycle_start_i)
      begin
         tmo_run_r <= 1'b1;
         tmo_cnt_r <= '0;
      end
      else if (subaction_gap_i)
      begin
         tmo_run_r <= 1'b0;
      end
      else if (tmo_run_r && tmo_cnt_r != 14'(link_pkt_pkg::CYCLE_TMOUT_CYC))
      begin
         tmo_cnt_r <= tmo_cnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event flags, set wins over clear
   always_comb
   begin
      ev_set = '0;
      ev_set[link_pkt_pkg::EV_RX_REQ_QAV]  = rx_req_wr;
      ev_set[link_pkt_pkg::EV_SELFID]      = rx_state_r == link_pkt_pkg::RX_SID_BODY
                                             && rx_valid_i && rx_is_selfid_i;
      ev_set[link_pkt_pkg::EV_CYCLE_TMOUT] = tmo_run_r && !subaction_gap_i
                                             && tmo_cnt_r == 14'(link_pkt_pkg::CYCLE_TMOUT_CYC - 1);
      ev_set[link_pkt_pkg::EV_RX_REQ_FULL] = rx_req_full;
      ev_set[link_pkt_pkg::EV_RX_RSP_FULL] = rx_rsp_full;
      iso_set = {iso_bad_packet_i, iso_tag_fault_i}
                & {2{ctrl_r[link_pkt_pkg::CTRL_ISO_RX_EN]}};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ev_r  <= '0;
         iso_r <= '0;
      end
      else
      begin
         if (bus_wr && wb_adr_i == link_pkt_pkg::OFS_ASYINT && wb_sel_i[0])
         begin
            ev_r <= (ev_r & ~wb_dat_i[4:0]) | ev_set;
         end
         else
         begin
            ev_r <= ev_r | ev_set;
         end
         if (!ctrl_r[link_pkt_pkg::CTRL_ISO_RX_EN])
         begin
            iso_r <= '0;
         end
         else if (bus_wr && wb_adr_i == link_pkt_pkg::OFS_ISO_INT && wb_sel_i[0])
         begin
            iso_r <= (iso_r & ~wb_dat_i[1:0]) | iso_set;
         end
         else
         begin
            iso_r <= iso_r | iso_set;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave, one wait-state ack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r         <= '0;
         cycle_master_o <= 1'b0;
      end
      else
      begin
         if (bus_wr && wb_adr_i == link_pkt_pkg::OFS_CTRL)
         begin
            ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
         end
         cycle_master_o <= ctrl_r[link_pkt_pkg::CTRL_CYCLE_MASTER];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= '0;
         if (bus_rd)
         begin
            unique case (wb_adr_i)
               link_pkt_pkg::OFS_CTRL:    wb_dat_o <= ctrl_r;
               link_pkt_pkg::OFS_STATUS:  wb_dat_o <= {22'h00_0000, rx_rsp_empty, rx_req_empty,
                                                       tx_rsp_full, 3'h0, tx_req_full, 1'b0,
                                                       tx_rsp_idle_r, tx_req_idle_r};
               link_pkt_pkg::OFS_ASYINT:  wb_dat_o <= {27'h000_0000, ev_r};
               link_pkt_pkg::OFS_RX_REQ:  wb_dat_o <= rx_req_empty ? 32'h0000_0000 : rx_req_rdata;
               link_pkt_pkg::OFS_RX_RSP:  wb_dat_o <= rx_rsp_empty ? 32'h0000_0000 : rx_rsp_rdata;
               link_pkt_pkg::OFS_ISO_INT: wb_dat_o <= {30'h0000_0000, iso_r};
               default:                   wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// >>> link_pkt_props.sv
// Port checker for link_pkt.
// Assumes a classic Wishbone master and a bind onto link_pkt.
`timescale 1ns/1ps
module link_pkt_props (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic       wb_ack_o,
   input wire logic       tx_req_pop_i,
   input wire logic       tx_rsp_pop_i,
   input wire logic       tx_req_avail_o,
   input wire logic       tx_rsp_avail_o,
   input wire logic       cycle_master_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rq;
   logic wq;
   logic wp;
   logic wc;
   assign rq = wb_cyc_i && wb_stb_i;
   assign wq = rq && wb_we_i && wb_adr_i == link_pkt_pkg::OFS_TX_REQ;
   assign wp = rq && wb_we_i && wb_adr_i == link_pkt_pkg::OFS_TX_RSP;
   assign wc = rq && wb_we_i && wb_adr_i == link_pkt_pkg::OFS_CTRL;
   property p_ack_next; rq && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held");
   property p_ack_cause; wb_ack_o |-> $past(rq); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_rst; $fell(rst_i) |-> !wb_ack_o && !cycle_master_o && !tx_req_avail_o
      && !tx_rsp_avail_o; endproperty
   a_rst: assert property (p_rst) else $error("reset value");
   property p_rq_fill; $rose(tx_req_avail_o) |-> $past(wq) || $past(wq, 2) || $past(wq, 3);
   endproperty
   a_rq_fill: assert property (p_rq_fill) else $error("req fill");
   property p_rp_fill; $rose(tx_rsp_avail_o) |-> $past(wp) || $past(wp, 2) || $past(wp, 3);
   endproperty
   a_rp_fill: assert property (p_rp_fill) else $error("rsp fill");
   property p_rq_drain; $fell(tx_req_avail_o) |-> $past(tx_req_pop_i) || $past(rst_i);
   endproperty
   a_rq_drain: assert property (p_rq_drain) else $error("req drain");
   property p_rp_drain; $fell(tx_rsp_avail_o) |-> $past(tx_rsp_pop_i) || $past(rst_i);
   endproperty
   a_rp_drain: assert property (p_rp_drain) else $error("rsp drain");
   property p_cm; $rose(cycle_master_o) |-> $past(wc) || $past(wc, 2); endproperty
   a_cm: assert property (p_cm) else $error("cycle master");
   c_fill: cover property ($rose(tx_req_avail_o));
   c_cm: cover property ($rose(cycle_master_o));
   c_rd: cover property (wb_ack_o && !wb_we_i && wb_adr_i == link_pkt_pkg::OFS_RX_REQ);
endmodule
bind link_pkt link_pkt_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
   .tx_req_pop_i(tx_req_pop_i), .tx_rsp_pop_i(tx_rsp_pop_i),
   .tx_req_avail_o(tx_req_avail_o), .tx_rsp_avail_o(tx_rsp_avail_o),
   .cycle_master_o(cycle_master_o));

// >>> phy_model.sv
// Far side model: drains transmit queues and plays bus traffic.
// Assumes its tasks are called from one process.
`timescale 1ns/1ps
module phy_model (
   input  wire logic        clk_i,
   input  wire logic        stall_i,
   input  wire logic        req_avail_i,
   input  wire logic        rsp_avail_i,
   output logic             req_pop_o = 0,
   output logic             rsp_pop_o = 0,
   output logic             rx_valid_o = 0,
   output logic [31:0]      rx_data_o = '0,
   output logic [5:0]       rx_flags_o = '0,
   output logic             done_o = 0,
   output logic             ack_o = 0,
   output logic             bcast_o = 0,
   output logic [9:0]       bus_id_o = '0,
   output logic [4:0]       ev_o = '0,
   output int               pops_o = 0
);
   // Pop every other cycle so the head can settle
   always @(posedge clk_i)
   begin
      req_pop_o <= req_avail_i && !stall_i && !req_pop_o;
      rsp_pop_o <= rsp_avail_i && !stall_i && !rsp_pop_o;
      pops_o <= pops_o + int'(req_pop_o) + int'(rsp_pop_o);
   end
   // Flags: first, last, response, solicited, selfid, phy
   task automatic rx(input logic [31:0] d, input logic [5:0] f);
      @(posedge clk_i);
      rx_valid_o <= 1;
      rx_data_o <= d;
      rx_flags_o <= f;
      @(posedge clk_i);
      rx_valid_o <= 0;
      rx_data_o <= ~d;
      rx_flags_o <= '0;
   endtask
   task automatic done(input logic a, input logic b, input logic [9:0] id);
      @(posedge clk_i);
      done_o <= 1;
      ack_o <= a;
      bcast_o <= b;
      bus_id_o <= id;
      @(posedge clk_i);
      done_o <= 0;
      bus_id_o <= ~id;
   endtask
   // Events: iso bad, iso tag, gap, cycle start, bus reset
   task automatic ev(input logic [4:0] m);
      @(posedge clk_i);
      ev_o <= m;
      @(posedge clk_i);
      ev_o <= '0;
   endtask
endmodule

// >>> link_pkt_tb.sv
// Testbench for link_pkt: Wishbone register tasks and directed checks.
// Assumes phy_model on the far side and the bound port checker.
`timescale 1ns/1ps
module link_pkt_tb;
   logic        clk_i = 0;
   logic        rst_i = 1;
   logic        cyc = 0;
   logic        stb = 0;
   logic        we = 0;
   logic        stall = 1;
   logic [7:0]  adr = '0;
   logic [31:0] dat = '0;
   logic [31:0] rdat;
   logic [31:0] dat_o, rqd, rpd, rxd;
   logic        ack, ra, pa, rp, pp, rv, td, as, bc, cm;
   logic [5:0]  fl;
   logic [9:0]  bid;
   logic [4:0]  ev;
   logic [9:0]  ids [4] = '{10'h000, 10'h3FE, 10'h002, 10'h3FF};
   int          n_errors = 0;
   int          total_checks = 0;
   int          cn = 0;
   int          p0;
   logic [3:0]  sel = 4'hF;
   localparam logic [7:0] ST = link_pkt_pkg::OFS_STATUS;
   localparam logic [7:0] AI = link_pkt_pkg::OFS_ASYINT;
   localparam logic [7:0] RQ = link_pkt_pkg::OFS_RX_REQ;
   localparam logic [7:0] CT = link_pkt_pkg::OFS_CTRL;
   always #5 clk_i = ~clk_i;
   link_pkt DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .tx_req_pop_i(rp), .tx_rsp_pop_i(pp), .tx_req_data_o(rqd), .tx_rsp_data_o(rpd),
      .tx_req_avail_o(ra), .tx_rsp_avail_o(pa), .rx_valid_i(rv), .rx_data_i(rxd),
      .rx_first_i(fl[5]), .rx_last_i(fl[4]), .rx_is_response_i(fl[3]),
      .rx_solicited_i(fl[2]), .rx_is_selfid_i(fl[1]), .rx_is_phy_i(fl[0]),
      .tx_done_i(td), .tx_ack_seen_i(as), .tx_ack_code_i(4'h0), .tx_broadcast_i(bc),
      .tx_bus_id_i(bid), .bus_reset_i(ev[0]), .cycle_start_i(ev[1]),
      .subaction_gap_i(ev[2]), .iso_tag_fault_i(ev[3]), .iso_bad_packet_i(ev[4]),
      .cycle_master_o(cm));
   phy_model u_phy (.clk_i(clk_i), .stall_i(stall), .req_avail_i(ra), .rsp_avail_i(pa),
      .req_pop_o(rp), .rsp_pop_o(pp), .rx_valid_o(rv), .rx_data_o(rxd), .rx_flags_o(fl),
      .done_o(td), .ack_o(as), .bcast_o(bc), .bus_id_o(bid), .ev_o(ev), .pops_o(p0));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      acc(0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask
   task automatic wt;
      do acc(0, ST, 32'h0000_0000); while (rdat[8] !== 1'b0);
   endtask
   task automatic end_sim;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cn <= cn + 1;
      if (cn == 60000)
      begin
         n_errors++;
         end_sim();
      end
   end
   initial
   begin
      int q;
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      rc(ST, 32'h0000_0303);
      rc(8'h40, 32'h0000_0000);
      for (int k = 0; k < 2; k++)
      begin
         for (int i = 0; i <= 64; i++)
            acc(1, k ? link_pkt_pkg::OFS_TX_RSP : link_pkt_pkg::OFS_TX_REQ, 32'h0000_1000 + i);
         rc(ST, k ? 32'h0000_0388 : 32'h0000_030A);
         chk(k ? rpd : rqd, 32'h0000_1000);
      end
      q = p0;
      stall <= 0;
      wait (ra === 1'b0 && pa === 1'b0);
      @(posedge clk_i);
      chk(p0 - q, 130);
      rc(ST, 32'h0000_0303);
      for (int i = 0; i < 4; i++)
      begin
         u_phy.done(0, i > 0, ids[i]);
         wt();
         acc(0, AI, 32'h0000_0000);
         chk(rdat[0], 1);
         rc(RQ, 32'h0000_00C0 | (i == 1 || i == 2));
         acc(1, AI, 32'h0000_001F);
      end
      u_phy.rx(32'h5555_0000, 6'b110000);
      u_phy.ev(5'b00001);
      u_phy.rx(32'h8123_4567, 6'b100010);
      u_phy.rx(32'h7EDC_BA98, 6'b010010);
      wt();
      rc(RQ, 32'h0000_00E0);
      rc(RQ, 32'h8123_4567);
      rc(RQ, 32'h7EDC_BA98);
      rc(RQ, 32'h0000_0001);
      acc(0, AI, 32'h0000_0000);
      chk(rdat[1], 1);
      u_phy.rx(32'h1234_5678, 6'b110001);
      wt();
      rc(RQ, 32'h0000_00E0);
      rc(RQ, 32'h1234_5678);
      for (int i = 0; i < 3; i++)
      begin
         if (i == 2)
            acc(1, CT, 32'h0000_0001);
         u_phy.rx(32'h0000_0A00 + i, {3'b111, i == 1, 2'b00});
         acc(0, ST, 32'h0000_0000);
         chk(rdat[9], i == 0);
         if (i > 0)
            rc(link_pkt_pkg::OFS_RX_RSP, 32'h0000_0A00 + i);
      end
      for (int i = 0; i < 2; i++)
      begin
         acc(1, CT, {30'h0, i[0], 1'b0});
         u_phy.ev(5'b11000);
         rc(link_pkt_pkg::OFS_ISO_INT, i ? 32'h0000_0003 : 32'h0000_0000);
         acc(1, link_pkt_pkg::OFS_ISO_INT, 32'h0000_0003);
      end
      acc(1, AI, 32'h0000_001F);
      acc(1, CT, 32'h0000_0800);
      u_phy.ev(5'b00010);
      repeat (100) @(posedge clk_i);
      u_phy.ev(5'b00100);
      repeat (12600) @(posedge clk_i);
      rc(AI, 32'h0000_0000);
      u_phy.ev(5'b00010);
      repeat (12400) @(posedge clk_i);
      rc(AI, 32'h0000_0000);
      repeat (200) @(posedge clk_i);
      rc(AI, 32'h0000_0004);
      sel <= 4'h2;
      acc(1, CT, 32'h0000_00FF);
      sel <= 4'hF;
      rc(CT, 32'h0000_0000);
      acc(1, AI, 32'h0000_0004);
      acc(1, CT, 32'h0000_0800);
      rc(AI, 32'h0000_0000);
      chk(cm, 1);
      end_sim();
   end
endmodule
